// [verilog/lspc_pkg.sv]
`default_nettype none
package lspc_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_CH = 48;
  localparam int GRP_CH = 16;
  localparam int GS_W = 16;
  localparam int NUM_STAGGER = 12;
  localparam int CH_PER_STAGGER = 4;
  localparam int WORD_W = 48;
  localparam int SCALE_W = 20;
  // ****************************************
  // Commands: number of link clock rises while latch is high
  // ****************************************
  localparam logic [3:0] CMD_GS_WRITE = 4'h1;
  localparam logic [3:0] CMD_GS_LATCH = 4'h3;
  localparam logic [3:0] CMD_FC_WRITE = 4'h5;
  localparam logic [3:0] CMD_LINE_WRAP = 4'h7;
  localparam logic [3:0] CMD_LINE_WRAP_CAT = 4'h9;
  // ****************************************
  // Function control word layout and reset values
  // ****************************************
  localparam int FC_GLOBAL_LSB = 0;
  localparam int FC_RED_LSB = 3;
  localparam int FC_GREEN_LSB = 12;
  localparam int FC_BLUE_LSB = 21;
  localparam int FC_LODT_LSB = 30;
  localparam int FC_DEPTH_LSB = 32;
  localparam logic [2:0] GLOBAL_RST = 3'h4;
  localparam logic [8:0] SCALE_RST = 9'h100;
  localparam logic [8:0] SCALE_FULL = 9'h1ff;
  localparam logic [1:0] LODT_RST = 2'h0;
  localparam logic [2:0] DEPTH_RST = 3'h7;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CORE_CLK_MHZ = 25;
  localparam int PRECHARGE_NS = 400;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_CYC = 4;
  localparam int GRAYSCALE_REF_CLOCK_HALF_CYC = 4;
  localparam int MIN_SEG_BITS = 9;

  // Gain in tenths for each global current code
  function automatic logic [10:0] gain_x10(input logic [2:0] code);
    case (code)
      3'h0: gain_x10 = 11'h0c8;
      3'h1: gain_x10 = 11'h18b;
      3'h2: gain_x10 = 11'h24a;
      3'h3: gain_x10 = 11'h329;
      3'h4: gain_x10 = 11'h3e8;
      3'h5: gain_x10 = 11'h46d;
      3'h6: gain_x10 = 11'h588;
      default: gain_x10 = 11'h609;
    endcase
  endfunction

  // Grayscale mask for PWM depth code 0..7 meaning 9..16 bits
  function automatic logic [15:0] depth_mask(input logic [2:0] depth);
    depth_mask = 16'hffff >> (3'h7 - depth);
  endfunction
endpackage
`default_nettype wire

// [verilog/lspc_link_if.sv]
`default_nettype none
interface lspc_link_if;
  logic sclk;
  logic sin;
  logic lat;
  logic grayscale_ref_clock;
  modport ctrl (output sclk, output sin, output lat, output grayscale_ref_clock);
  modport dev (input sclk, input sin, input lat, input grayscale_ref_clock);
endinterface
`default_nettype wire

// [verilog/lspc_dev.sv]
// Notes on behaviour
// [RULE_01] Reset: outputs off, counters and settings initial
// [RULE_02] Controller writes settings only when needed
// [RULE_03] Grayscale loaded in 48-bit groups, latched
// [RULE_04] Controller supplies continuous 2^N grayscale clocks
// [RULE_05] Next line loaded during segment; wrap command
// [RULE_06] 3-bit global code scales all outputs
// [RULE_07] Global code resets to 4h
// [RULE_08] Three 9-bit colour scales reset 100h
// [RULE_09] Scale changes act immediately
// [RULE_10] Group current is max times code/511
// [RULE_11] Global code selects documented gain table
// [RULE_12] Open flag set when output voltage low
// [RULE_13] Open flag zero while output off
// [RULE_14] PWM depth selectable 9 to 16 bits
// [RULE_15] Wrap command arms suppression; broken stays dark
// [RULE_16] Pre-charge pull-up during line switching
// [RULE_17] Over-temperature forces all outputs off
// [RULE_18] Reference short forces all outputs off
// [RULE_19] Twelve groups switch on one after another
// [RULE_20] 48 outputs, three colours, 16-bit grayscale
// [RULE_21] Counter on grayscale clock rise; on below value
`default_nettype none
module lspc_dev
  import lspc_pkg::*;
(
  input wire logic core_clk, // 25 MHz
  input wire logic rst_n, // Sync reset
  lspc_link_if.dev link, // Serial and grayscale pins
  input wire logic over_temperature_flag, // Thermal fault, async
  input wire logic ref_resistor_short_flag, // Reference short, async
  input wire logic [NUM_CH-1:0] out_low_sense, // Output below open threshold, async
  output logic [NUM_CH-1:0] sink_output_n, // 1 = sink on
  output logic [NUM_CH-1:0] open_led_flag, // Open detect per output
  output logic precharge_on, // Pre-charge pull-up enable
  output logic [1:0] open_detect_threshold_sel, // Threshold to comparators
  output logic [2:0] global_current_code, // Global code
  output logic [8:0] red_group_scale, // Red colour code
  output logic [8:0] green_group_scale, // Green colour code
  output logic [8:0] blue_group_scale, // Blue colour code
  output logic [2:0][SCALE_W-1:0] group_gain_x10 // Effective gain per colour, tenths
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] sin_s;
    logic [1:0] lat_s;
    logic [1:0] grayscale_ref_clock_s;
    logic [1:0] temp_s;
    logic [1:0] short_s;
    logic [1:0][NUM_CH-1:0] low_s;
    logic sclk_p;
    logic lat_p;
    logic grayscale_ref_clock_p;
    logic [WORD_W-1:0] shift;
    logic [3:0] cmd_cnt;
    logic [3:0] grp_idx;
    logic [NUM_CH-1:0][GS_W-1:0] gs_wr;
    logic [NUM_CH-1:0][GS_W-1:0] gs_disp;
    logic [2:0] glob;
    logic [2:0][8:0] scale;
    logic [1:0] lodt;
    logic [2:0] depth;
    logic cat_en;
    logic [NUM_CH-1:0] dead;
    logic [GS_W-1:0] gs_cnt;
    logic [3:0] stagger;
    logic [7:0] pre_cnt;
    logic [NUM_CH-1:0] sink;
    logic [NUM_CH-1:0] open;
    logic pre;
    logic [2:0][SCALE_W-1:0] gain;
  } lspc_dev_st_t;

  lspc_dev_st_t q;
  lspc_dev_st_t d;

  function automatic logic [SCALE_W-1:0] scaled_gain(input logic [2:0] g, input logic [8:0] c);
    logic [SCALE_W-1:0] prod;
    prod = SCALE_W'(gain_x10(g)) * SCALE_W'(c);
    scaled_gain = prod / SCALE_W'(SCALE_FULL);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic sclk_rise;
    logic lat_fall;
    logic grayscale_ref_clock_rise;
    logic faulted;
    logic [15:0] mask;
    logic [5:0] ch;
    sclk_rise = 1'b0;
    lat_fall = 1'b0;
    grayscale_ref_clock_rise = 1'b0;
    faulted = 1'b0;
    mask = 16'h0000;
    ch = 6'h00;
    d = q;
    // Two-stage synchronisers; stage 0 feeds stage 1 only
    d.sclk_s = {q.sclk_s[0], link.sclk};
    d.sin_s = {q.sin_s[0], link.sin};
    d.lat_s = {q.lat_s[0], link.lat};
    d.grayscale_ref_clock_s = {q.grayscale_ref_clock_s[0], link.grayscale_ref_clock};
    d.temp_s = {q.temp_s[0], over_temperature_flag};
    d.short_s = {q.short_s[0], ref_resistor_short_flag};
    d.low_s = {q.low_s[0], out_low_sense};
    d.sclk_p = q.sclk_s[1];
    d.lat_p = q.lat_s[1];
    d.grayscale_ref_clock_p = q.grayscale_ref_clock_s[1];
    sclk_rise = q.sclk_s[1] & ~q.sclk_p;
    lat_fall = ~q.lat_s[1] & q.lat_p;
    grayscale_ref_clock_rise = q.grayscale_ref_clock_s[1] & ~q.grayscale_ref_clock_p;
    mask = depth_mask(q.depth); // [RULE_14]

    // ****************************************
    // Serial word and command framing
    // ****************************************
    if (sclk_rise) begin
      d.shift = {q.shift[WORD_W-2:0], q.sin_s[1]};
      if (q.lat_s[1] && q.cmd_cnt != 4'hf) begin
        d.cmd_cnt = q.cmd_cnt + 4'h1;
      end
    end
    if (lat_fall) begin
      d.cmd_cnt = 4'h0;
      case (q.cmd_cnt)
        CMD_GS_WRITE, CMD_GS_LATCH, CMD_LINE_WRAP, CMD_LINE_WRAP_CAT: begin
          // One group carries the same channel of all three colours
          d.gs_wr[q.grp_idx] = q.shift[47:32]; // [RULE_03] [RULE_20]
          d.gs_wr[q.grp_idx + 5'd16] = q.shift[31:16];
          d.gs_wr[q.grp_idx + 6'd32] = q.shift[15:0];
          d.grp_idx = q.grp_idx + 4'h1;
          if (q.cmd_cnt != CMD_GS_WRITE) begin
            d.gs_disp = d.gs_wr; // [RULE_03] [RULE_05]
            d.grp_idx = 4'h0;
          end
          if (q.cmd_cnt == CMD_LINE_WRAP || q.cmd_cnt == CMD_LINE_WRAP_CAT) begin
            d.cat_en = (q.cmd_cnt == CMD_LINE_WRAP_CAT); // [RULE_15]
          end
        end
        CMD_FC_WRITE: begin
          d.glob = q.shift[FC_GLOBAL_LSB +: 3]; // [RULE_06] [RULE_09]
          d.scale[0] = q.shift[FC_RED_LSB +: 9]; // [RULE_08] [RULE_09]
          d.scale[1] = q.shift[FC_GREEN_LSB +: 9];
          d.scale[2] = q.shift[FC_BLUE_LSB +: 9];
          d.lodt = q.shift[FC_LODT_LSB +: 2];
          d.depth = q.shift[FC_DEPTH_LSB +: 3]; // [RULE_14]
        end
        default: begin
          d.cmd_cnt = 4'h0;
        end
      endcase
    end

    // ****************************************
    // Grayscale counter, segments, stagger, pre-charge
    // ****************************************
    // Stagger waits for pre-charge to end, else the groups would light together
    if (q.pre_cnt != 8'h00) begin
      d.pre_cnt = q.pre_cnt - 8'h01;
    end else if (q.stagger != 4'(NUM_STAGGER)) begin
      d.stagger = q.stagger + 4'h1; // [RULE_19]
    end
    if (grayscale_ref_clock_rise) begin
      if ((q.gs_cnt & mask) == mask) begin
        d.gs_cnt = 16'h0000;
        // New segment: line supply is switching now
        d.stagger = 4'h0; // [RULE_19]
        d.pre_cnt = 8'(PRECHARGE_CYC); // [RULE_16]
      end else begin
        d.gs_cnt = (q.gs_cnt + 16'h0001) & mask; // [RULE_21]
      end
    end
    d.pre = (q.pre_cnt != 8'h00); // [RULE_16]

    // ****************************************
    // Outputs, faults and open detect
    // ****************************************
    faulted = q.temp_s[1] | q.short_s[1]; // [RULE_17] [RULE_18]
    for (int i = 0; i < NUM_CH; i++) begin
      ch = 6'(i);
      d.sink[i] = ((q.gs_cnt & mask) < (q.gs_disp[i] & mask)) // [RULE_21]
        && (4'(ch / 6'(CH_PER_STAGGER)) < q.stagger) // [RULE_19]
        && !faulted && !q.dead[i] && (q.pre_cnt == 8'h00); // [RULE_15] [RULE_17] [RULE_18]
      // Comparator result only counts while the sink is on
      d.open[i] = q.sink[i] & q.low_s[1][i]; // [RULE_12] [RULE_13]
      if (q.cat_en && q.open[i]) begin
        d.dead[i] = 1'b1; // [RULE_15]
      end
    end
    for (int k = 0; k < 3; k++) begin
      d.gain[k] = scaled_gain(q.glob, q.scale[k]); // [RULE_06] [RULE_10] [RULE_11]
    end

    if (!rst_n) begin
      d = '0; // [RULE_01]
      d.glob = GLOBAL_RST; // [RULE_07]
      d.scale = {SCALE_RST, SCALE_RST, SCALE_RST}; // [RULE_08]
      d.lodt = LODT_RST;
      d.depth = DEPTH_RST;
      d.gain = {3{scaled_gain(GLOBAL_RST, SCALE_RST)}};
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign sink_output_n = q.sink;
  assign open_led_flag = q.open;
  assign precharge_on = q.pre;
  assign open_detect_threshold_sel = q.lodt;
  assign global_current_code = q.glob;
  assign red_group_scale = q.scale[0];
  assign green_group_scale = q.scale[1];
  assign blue_group_scale = q.scale[2];
  assign group_gain_x10 = q.gain;
endmodule // lspc_dev
`default_nettype wire

// [verilog/lspc_ctrl.sv]
`default_nettype none
module lspc_ctrl
  import lspc_pkg::*;
(
  input wire logic core_clk, // 25 MHz
  input wire logic rst_n, // Sync reset
  lspc_link_if.ctrl link, // Pins toward the driver
  input wire logic req_valid, // Send one word, one-cycle pulse
  input wire logic [3:0] req_cmd, // Command code
  input wire logic [WORD_W-1:0] req_data, // Word, sent msb first
  output logic busy, // Word in flight
  input wire logic grayscale_ref_clock_run, // Run the grayscale clock
  input wire logic [2:0] seg_depth, // Segment 2^(9+code) clocks
  output logic segment_end // Pulse: switch line supply now
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_GAP = 2'b11
  } lspc_ctrl_state_t;

  typedef struct packed {
    lspc_ctrl_state_t st;
    logic [WORD_W-1:0] word;
    logic [3:0] cmd;
    logic [5:0] bit_left;
    logic [3:0] div;
    logic sclk;
    logic sin;
    logic lat;
    logic busy;
    logic [3:0] gdiv;
    logic grayscale_ref_clock;
    logic [15:0] gcnt;
    logic seg_end;
  } lspc_ctrl_st_t;

  lspc_ctrl_st_t q;
  lspc_ctrl_st_t d;

  always_comb begin
    d = q;
    d.seg_end = 1'b0;
    // ****************************************
    // Serial word: lat high over the last cmd bits
    // ****************************************
    case (q.st)
      ST_IDLE: begin
        if (req_valid) begin
          // Settings writes are only sent when the user asks for them
          d.word = req_data; // [RULE_02] [RULE_03]
          d.cmd = req_cmd;
          d.bit_left = 6'(WORD_W);
          d.busy = 1'b1;
          d.sin = req_data[WORD_W-1];
          // Compare at six bits; the word length does not fit in four
          d.lat = (6'(req_cmd) >= 6'(WORD_W));
          d.div = 4'(SCLK_HALF_CYC - 1);
          d.st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (q.div == 4'h0) begin
          d.sclk = 1'b1;
          d.div = 4'(SCLK_HALF_CYC - 1);
          d.st = ST_HIGH;
        end else begin
          d.div = q.div - 4'h1;
        end
      end
      ST_HIGH: begin
        if (q.div == 4'h0) begin
          d.sclk = 1'b0;
          d.div = 4'(SCLK_HALF_CYC - 1);
          d.bit_left = q.bit_left - 6'h01;
          d.word = {q.word[WORD_W-2:0], 1'b0};
          d.sin = q.word[WORD_W-2];
          d.lat = (q.bit_left - 6'h01 <= 6'(q.cmd)) && (q.bit_left != 6'h01);
          d.st = (q.bit_left == 6'h01) ? ST_GAP : ST_LOW;
        end else begin
          d.div = q.div - 4'h1;
        end
      end
      ST_GAP: begin
        // Latch low long enough for the far end to see the fall
        d.lat = 1'b0;
        if (q.div == 4'h0) begin
          d.busy = 1'b0;
          d.st = ST_IDLE;
        end else begin
          d.div = q.div - 4'h1;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // ****************************************
    // Grayscale clock, counted into segments
    // ****************************************
    if (grayscale_ref_clock_run) begin
      if (q.gdiv == 4'h0) begin
        d.gdiv = 4'(GRAYSCALE_REF_CLOCK_HALF_CYC - 1);
        d.grayscale_ref_clock = ~q.grayscale_ref_clock;
        if (!q.grayscale_ref_clock) begin
          if (q.gcnt == depth_mask(seg_depth)) begin
            d.gcnt = 16'h0000;
            d.seg_end = 1'b1; // [RULE_04] [RULE_05]
          end else begin
            d.gcnt = q.gcnt + 16'h0001; // [RULE_04]
          end
        end
      end else begin
        d.gdiv = q.gdiv - 4'h1;
      end
    end

    if (!rst_n) begin
      d = '0;
      d.st = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign link.sclk = q.sclk;
  assign link.sin = q.sin;
  assign link.lat = q.lat;
  assign link.grayscale_ref_clock = q.grayscale_ref_clock;
  assign busy = q.busy;
  assign segment_end = q.seg_end;
endmodule // lspc_ctrl
`default_nettype wire

// [dv/lspc_link_properties.sv]
`default_nettype none
module lspc_link_properties
  import lspc_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Sync reset
  input wire logic sclk, // Serial clock
  input wire logic sin, // Serial data
  input wire logic grayscale_ref_clock, // Grayscale clock
  input wire logic over_temperature_flag, // Thermal fault
  input wire logic ref_resistor_short_flag, // Reference short
  input wire logic [NUM_CH-1:0] sink_output_n, // Sinks
  input wire logic [NUM_CH-1:0] open_led_flag, // Open flags
  input wire logic precharge_on, // Pre-charge
  input wire logic segment_end, // Line switch pulse from controller
  input wire logic [2:0] global_current_code // Global code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Reset and faults
  // ****************************************
  a_reset_dark: assert property (disable iff (1'b0) !rst_n |=> sink_output_n == '0 && !precharge_on)
    else $error("sinks lit after reset");
  a_reset_code: assert property (disable iff (1'b0) !rst_n |=> global_current_code == GLOBAL_RST)
    else $error("global code not initial");
  // Margin of one cycle over the two-stage synchroniser and the sink register
  a_heat_blank: assert property (over_temperature_flag [*4] |=> sink_output_n == '0)
    else $error("sinks lit while hot");
  a_short_blank: assert property (ref_resistor_short_flag [*4] |=> sink_output_n == '0)
    else $error("sinks lit while reference shorted");
  a_open_off: assert property ((open_led_flag & ~$past(sink_output_n)) == '0)
    else $error("open flag on dark output");
  // ****************************************
  // Segment switching
  // ****************************************
  a_pre_dark: assert property (precharge_on && $past(precharge_on) |-> sink_output_n == '0)
    else $error("sinks lit during pre-charge");
  // Two sync stages, counter wrap, then pre-charge register
  a_seg_pre: assert property (segment_end |-> ##4 $rose(precharge_on))
    else $error("pre-charge not started at segment end");
  // Ten cycles high, then low
  a_pre_len: assert property ($rose(precharge_on) |-> precharge_on [*8] ##1 precharge_on [*2] ##1 !precharge_on)
    else $error("pre-charge length wrong");
  // ****************************************
  // Link pins
  // ****************************************
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock half period wrong");
  a_sin_hold: assert property (sclk |-> $stable(sin))
    else $error("serial data moved while clock high");
  a_grayscale_ref_clock_half: assert property ($rose(grayscale_ref_clock) |-> grayscale_ref_clock [*4] ##1 !grayscale_ref_clock)
    else $error("grayscale clock half period wrong");
endmodule // lspc_link_properties
`default_nettype wire

// [dv/lspc_bench.sv]
`default_nettype none
module lspc_bench
  import lspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_cmd = 4'h0;
  logic [WORD_W-1:0] req_data = '0;
  logic grayscale_ref_clock_run = 1'b0;
  logic [2:0] seg_depth = 3'h0;
  logic over_temperature_flag = 1'b0;
  logic ref_resistor_short_flag = 1'b0;
  logic [NUM_CH-1:0] out_low_sense = '0;
  logic busy, precharge_on, segment_end;
  logic [NUM_CH-1:0] sink_output_n, open_led_flag;
  logic [1:0] open_detect_threshold_sel;
  logic [2:0] global_current_code;
  logic [8:0] red_group_scale, green_group_scale, blue_group_scale;
  logic [2:0][SCALE_W-1:0] group_gain_x10;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int g10[8] = '{200, 395, 586, 809, 1000, 1133, 1416, 1545};
  lspc_link_if link ();
  lspc_ctrl i_lspc_ctrl (.core_clk(core_clk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_data(req_data), .busy(busy), .grayscale_ref_clock_run(grayscale_ref_clock_run), .seg_depth(seg_depth),
    .segment_end(segment_end));
  lspc_dev i_lspc_dev (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .over_temperature_flag(over_temperature_flag), .ref_resistor_short_flag(ref_resistor_short_flag),
    .out_low_sense(out_low_sense), .sink_output_n(sink_output_n), .open_led_flag(open_led_flag),
    .precharge_on(precharge_on), .open_detect_threshold_sel(open_detect_threshold_sel),
    .global_current_code(global_current_code), .red_group_scale(red_group_scale),
    .green_group_scale(green_group_scale), .blue_group_scale(blue_group_scale),
    .group_gain_x10(group_gain_x10));
  lspc_link_properties i_lspc_link_properties (.core_clk(core_clk), .rst_n(rst_n), .sclk(link.sclk),
    .sin(link.sin), .grayscale_ref_clock(link.grayscale_ref_clock), .over_temperature_flag(over_temperature_flag),
    .ref_resistor_short_flag(ref_resistor_short_flag), .sink_output_n(sink_output_n),
    .open_led_flag(open_led_flag), .precharge_on(precharge_on), .segment_end(segment_end),
    .global_current_code(global_current_code));
  always #20 core_clk = ~core_clk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded poll; outputs read at the falling edge to stay clear of updates
  task automatic wait_sinks(input logic [47:0] m, input logic [47:0] v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while ((sink_output_n & m) !== v && n < lim);
    chk("sinks", v, sink_output_n & m);
  endtask
  task automatic wait_pre;
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (precharge_on !== 1'b1 && n < 6000);
    chk("precharge", 48'h1, 48'(precharge_on));
  endtask
  task automatic send(input logic [3:0] cmd, input logic [WORD_W-1:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_cmd <= cmd;
    req_data <= d;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 600);
    chk("busy", '0, 48'(busy));
  endtask
  // Every channel gets a value whose upper bits fall outside a 9-bit depth
  task automatic load(input logic [3:0] last);
    for (int g = 0; g < GRP_CH; g++)
      send((g == GRP_CH - 1) ? last : CMD_GS_WRITE, {3{16'hfe80}});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("sinks", '0, sink_output_n);
    chk("global", 48'(GLOBAL_RST), 48'(global_current_code));
    chk("scales", 48'({3{SCALE_RST}}), 48'({red_group_scale, green_group_scale, blue_group_scale}));
    chk("gain", 48'(1000 * 256 / 511), 48'(group_gain_x10[2]));
  endtask
  task automatic t_gain;
    for (int c = 0; c < 8; c++) begin
      send(CMD_FC_WRITE, {13'h0, 3'h0, 2'(c), 9'h100, 9'h000, 9'h1ff, 3'(c)});
      repeat (8) @(negedge core_clk);
      chk("global", 48'(c), 48'(global_current_code));
      chk("threshold", 48'(c % 4), 48'(open_detect_threshold_sel));
      chk("red gain", 48'(g10[c]), 48'(group_gain_x10[0]));
      chk("green gain", '0, 48'(group_gain_x10[1]));
      chk("blue gain", 48'(g10[c] * 256 / 511), 48'(group_gain_x10[2]));
    end
  endtask
  task automatic t_segment;
    @(posedge core_clk);
    grayscale_ref_clock_run <= 1'b1;
    wait_pre();
    wait_sinks(48'h1, 48'h1, 60);
    chk("first group", 48'h0000_0000_000f, sink_output_n);
    wait_sinks('1, '1, 30);
    @(posedge core_clk);
    out_low_sense <= 48'h0000_0000_0020;
    repeat (4) @(negedge core_clk);
    chk("open", 48'h0000_0000_0020, open_led_flag);
    @(posedge core_clk);
    out_low_sense <= '0;
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      {ref_resistor_short_flag, over_temperature_flag} <= 2'(1 << k);
      repeat (5) @(negedge core_clk);
      chk("blanked", '0, sink_output_n);
      @(posedge core_clk);
      {ref_resistor_short_flag, over_temperature_flag} <= 2'h0;
      wait_sinks('1, '1, 20);
    end
  endtask
  // On time of one channel: 128 counts of 8 cycles less the pre-charge
  task automatic t_width;
    int n;
    int e;
    n = 0;
    e = 128 * 2 * GRAYSCALE_REF_CLOCK_HALF_CYC - PRECHARGE_CYC;
    wait_pre();
    wait_sinks(48'h1, 48'h1, 60);
    while (sink_output_n[0] === 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    chk("on time", 48'h1, 48'(n inside {[e - 4:e]}));
  endtask
  task automatic t_dead;
    load(CMD_LINE_WRAP_CAT);
    wait_pre();
    wait_sinks('1, '1, 60);
    @(posedge core_clk);
    out_low_sense <= 48'h0000_0000_0080;
    repeat (6) @(posedge core_clk);
    out_low_sense <= '0;
    wait_pre();
    wait_sinks('1, 48'hffff_ffff_ff7f, 60);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_gain();
    load(CMD_GS_LATCH);
    t_segment();
    t_width();
    t_dead();
    end_of_test();
  end
endmodule // lspc_bench
`default_nettype wire
